// *** include/ebt_pkg.sv ***
// Package for the eight-bit period timer: register offsets, field layout, reset values.
// Assumes a simple strobe register port with 8-bit data in the low bits of a byte address.
package ebt_pkg;
   localparam int unsigned        EBT_ADDR_W       = 4;
   localparam logic [3:0]         EBT_OFS_COUNTER  = 4'h0;
   localparam logic [3:0]         EBT_OFS_LIMIT    = 4'h4;
   localparam logic [3:0]         EBT_OFS_CONTROL  = 4'h8;
   localparam logic [3:0]         EBT_OFS_FLAGS    = 4'hC;
   localparam int unsigned        EBT_RUN_BIT      = 2;
   localparam int unsigned        EBT_IDIV_LSB     = 0;
   localparam int unsigned        EBT_MDIV_LSB     = 3;
   localparam int unsigned        EBT_FLAG_BIT     = 1;
   localparam logic [7:0]         EBT_COUNTER_RST  = 8'h00;
   localparam logic [7:0]         EBT_LIMIT_RST    = 8'hFF;
   localparam logic [6:0]         EBT_CONTROL_RST  = 7'h00;
   localparam logic [1:0]         EBT_QUARTER      = 2'h3;
   localparam logic [3:0]         EBT_PRE_DIV4     = 4'h3;
   localparam logic [3:0]         EBT_PRE_DIV16    = 4'hF;
   typedef enum logic [1:0] {
      EBT_IDIV_1  = 2'b00,
      EBT_IDIV_4  = 2'b01,
      EBT_IDIV_16 = 2'b10
   } ebt_idiv_t;
endpackage : ebt_pkg

// *** src/ebt_timer.sv ***
// Eight-bit period timer with prescaler, period match and postscaler flag.
// Assumes mclk_i is the oscillator clock; register strobes are synchronous one-cycle pulses.
//
// Function
// RL1: The count clock is the oscillator divided by four, fed through the prescaler.
// RL2: The counter and the period limit registers are each eight bits wide.
// RL3: The input divide select gives divide by 1 for 00, by 4 for 01 and by 16 for 1x.
// RL4: Each prescaler output pulse advances the period counter by one.
// RL5: The counter counts up from zero and is compared continuously with the period limit.
// RL6: On the increment event after a match the counter loads zero instead of incrementing.
// RL7: Every match pulse advances the postscaler by one.
// RL8: Control bits 6 to 3 set the postscaler ratio from 1:1 for 0000 up to 1:16 for 1111.
// RL9: Each postscaler output sets the period match flag in the peripheral flag register.
// RL10: Software can read and write the counter and period limit at any time.
// RL11: Reset loads the counter with zero and the period limit with all ones.
// RL12: Control bit 2 starts the timer when one and stops it when zero.
// RL13: Writes to the counter or control register and any reset clear prescaler and postscaler.
// RL14: A control register write leaves the counter value unchanged.
// RL15: While stopped, counter, prescaler and postscaler hold and no match or flag set occurs.
// RL16: The period match flag stays set until software writes it to zero.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module ebt_timer (
   // Clock and reset
   input  wire logic                          mclk_i,
   input  wire logic                          resetn_i,
   // Register port
   input  wire logic [ebt_pkg::EBT_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]                    wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic      [7:0]                    rdata_o,
   // Events
   output logic                               match_o,
   output logic                               period_match_flag_o
);
   import ebt_pkg::*;

   logic [7:0] period_counter, next_period_counter;
   logic [7:0] period_limit, next_period_limit;
   logic [6:0] counter_control, next_counter_control;
   logic [1:0] quarter, next_quarter;
   logic [3:0] pre_cnt, next_pre_cnt;
   logic [3:0] post_cnt, next_post_cnt;
   logic       flag, next_flag;
   logic [7:0] next_rdata;
   logic       counter_run;
   logic [1:0] input_divide_select;
   logic [3:0] match_divide_select;
   logic       inst_tick, pre_tick, at_limit, match, post_tick;
   logic       wr_counter, wr_limit, wr_control, wr_flags;

   function automatic logic [3:0] pre_last(input logic [1:0] sel);
      if (sel[1])
         pre_last = EBT_PRE_DIV16; // [RL3]
      else if (sel == EBT_IDIV_4)
         pre_last = EBT_PRE_DIV4;
      else
         pre_last = 4'h0;
   endfunction

   assign counter_run         = counter_control[EBT_RUN_BIT];
   assign input_divide_select = counter_control[EBT_IDIV_LSB +: 2];
   assign match_divide_select = counter_control[EBT_MDIV_LSB +: 4];
   assign wr_counter          = wr_i && (addr_i == EBT_OFS_COUNTER);
   assign wr_limit            = wr_i && (addr_i == EBT_OFS_LIMIT);
   assign wr_control          = wr_i && (addr_i == EBT_OFS_CONTROL);
   assign wr_flags            = wr_i && (addr_i == EBT_OFS_FLAGS);
   // The quarter divider runs free so the instruction clock phase is not disturbed by writes.
   assign inst_tick           = (quarter == EBT_QUARTER); // [RL1]
   assign pre_tick            = counter_run && inst_tick && (pre_cnt == pre_last(input_divide_select)); // [RL4] [RL15]
   assign at_limit            = (period_counter == period_limit); // [RL5]
   assign match               = pre_tick && at_limit && !wr_counter;
   assign post_tick           = match && (post_cnt == match_divide_select) && !wr_control; // [RL8]
   assign match_o             = match;
   assign period_match_flag_o = flag;

   always_comb begin
      next_quarter         = quarter + 2'h1;
      next_period_counter  = period_counter;
      next_period_limit    = period_limit;
      next_counter_control = counter_control;
      next_pre_cnt         = pre_cnt;
      next_post_cnt        = post_cnt;
      next_flag            = flag;
      if (counter_run && inst_tick) begin
         next_pre_cnt = pre_tick ? 4'h0 : pre_cnt + 4'h1; // [RL15]
      end
      if (pre_tick) begin
         next_period_counter = at_limit ? EBT_COUNTER_RST : period_counter + 8'h01; // [RL4] [RL6]
      end
      if (match) begin
         next_post_cnt = (post_cnt == match_divide_select) ? 4'h0 : post_cnt + 4'h1; // [RL7]
      end
      if (wr_counter) begin
         next_period_counter = wdata_i; // [RL10]
      end
      if (wr_limit) begin
         next_period_limit = wdata_i; // [RL10]
      end
      if (wr_control) begin
         next_counter_control = wdata_i[6:0]; // [RL12] [RL14]
      end
      if (wr_counter || wr_control) begin
         next_pre_cnt  = 4'h0; // [RL13]
         next_post_cnt = 4'h0;
      end
      if (wr_flags) begin
         next_flag = wdata_i[EBT_FLAG_BIT];
      end
      if (post_tick) begin
         next_flag = 1'b1; // [RL9] [RL16]
      end
      case (addr_i)
         EBT_OFS_COUNTER: next_rdata = period_counter;
         EBT_OFS_LIMIT:   next_rdata = period_limit;
         EBT_OFS_CONTROL: next_rdata = {1'b0, counter_control};
         EBT_OFS_FLAGS:   next_rdata = {6'h00, flag, 1'b0};
         default:         next_rdata = 8'h00;
      endcase
      if (!rd_i) begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         quarter         <= 2'h0;
         period_counter  <= EBT_COUNTER_RST; // [RL11] [RL2]
         period_limit    <= EBT_LIMIT_RST;
         counter_control <= EBT_CONTROL_RST;
         pre_cnt         <= 4'h0; // [RL13]
         post_cnt        <= 4'h0;
         flag            <= 1'b0;
         rdata_o         <= 8'h00;
      end else begin
         quarter         <= next_quarter;
         period_counter  <= next_period_counter;
         period_limit    <= next_period_limit;
         counter_control <= next_counter_control;
         pre_cnt         <= next_pre_cnt;
         post_cnt        <= next_post_cnt;
         flag            <= next_flag;
         rdata_o         <= next_rdata;
      end
   end

   logic [6:0] idle_cycles;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i)
         idle_cycles <= 7'h00;
      else if (pre_tick || wr_counter || wr_control || !counter_run)
         idle_cycles <= 7'h00;
      else
         idle_cycles <= idle_cycles + 7'h01;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   tick_spacing_a: assert property (idle_cycles <= 7'h40) // [RL1]
      else $error("Prescaler tick missing.");
   div1_rate_a: assert property (counter_run && input_divide_select == 2'h0 && pre_tick
      && !wr_counter && !wr_control ##1 (counter_run && !wr_counter && !wr_control) [*3] |=> pre_tick) // [RL3]
      else $error("Divide by one rate wrong.");
   count_inc_a: assert property (pre_tick && !at_limit && !wr_counter |=> period_counter == $past(period_counter) + 8'h01) // [RL4]
      else $error("Counter did not advance.");
   wrap_zero_a: assert property (pre_tick && at_limit && !wr_counter |=> period_counter == 8'h00) // [RL6]
      else $error("Counter did not wrap.");
   flag_set_a: assert property (post_tick |=> flag) // [RL9]
      else $error("Flag not set.");
   limit_write_a: assert property (wr_limit |=> period_limit == $past(wdata_i)) // [RL10]
      else $error("Limit write lost.");
   ctrl_keep_a: assert property (wr_control && !pre_tick |=> $stable(period_counter)) // [RL14]
      else $error("Control write moved counter.");
   write_clear_a: assert property (wr_counter || wr_control |=> pre_cnt == 4'h0 && post_cnt == 4'h0) // [RL13]
      else $error("Scalers not cleared.");
   stop_hold_a: assert property (!counter_run && !wr_counter |=> $stable(period_counter)) // [RL15]
      else $error("Counter moved while stopped.");
   flag_sticky_a: assert property (flag && !wr_flags |=> flag) // [RL16]
      else $error("Flag dropped.");
   post_one_a: assert property (match && match_divide_select == 4'h0 && !wr_control |=> flag) // [RL8]
      else $error("Postscale 1:1 failed.");

   // Cycles since the last prescaler tick, and whether that gap ran undisturbed.
   // A counter or control write or a stop breaks the gap, so the rate checks only judge clean intervals.
   logic [6:0] since_tick;
   logic       clean_gap;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         since_tick <= 7'h00;
         clean_gap  <= 1'b0;
      end else if (pre_tick) begin
         since_tick <= 7'h00;
         clean_gap  <= !wr_counter && !wr_control;
      end else begin
         since_tick <= since_tick + 7'h01;
         clean_gap  <= clean_gap && counter_run && !wr_counter && !wr_control;
      end
   end

   // Tick rates: the instruction clock is four oscillator cycles, then the prescale ratio.
   rate_div1_a: assert property (pre_tick && clean_gap && input_divide_select == 2'h0 // [RL1]
      |-> since_tick == 7'h03)
      else $error("Divide by one spacing wrong.");

   rate_div4_a: assert property (pre_tick && clean_gap && input_divide_select == 2'h1 // [RL3]
      |-> since_tick == 7'h0F)
      else $error("Divide by four spacing wrong.");

   rate_div16_a: assert property (pre_tick && clean_gap && input_divide_select[1] // [RL3]
      |-> since_tick == 7'h3F)
      else $error("Divide by sixteen spacing wrong.");

   pre_bound_a: assert property (1'b1 // [RL3]
      |-> pre_cnt <= pre_last(input_divide_select))
      else $error("Prescaler past its ratio.");

   // Counter and match behaviour.
   counter_tick_a: assert property (!pre_tick && !wr_counter // [RL4]
      |=> $stable(period_counter))
      else $error("Counter moved without a tick.");

   match_limit_a: assert property (match // [RL5]
      |-> at_limit && counter_run)
      else $error("Match without equality.");

   counter_write_a: assert property (wr_counter // [RL10]
      |=> period_counter == $past(wdata_i))
      else $error("Counter write lost.");

   limit_hold_a: assert property (!wr_limit // [RL10]
      |=> $stable(period_limit))
      else $error("Limit changed without a write.");

   // Postscaler behaviour.
   post_adv_a: assert property (match && post_cnt != match_divide_select && !wr_control // [RL7]
      |=> post_cnt == $past(post_cnt) + 4'h1)
      else $error("Postscaler did not advance.");

   post_bound_a: assert property (1'b1 // [RL8]
      |-> post_cnt <= match_divide_select)
      else $error("Postscaler past its ratio.");

   post_wrap_a: assert property (post_tick // [RL8]
      |=> post_cnt == 4'h0)
      else $error("Postscaler did not restart.");

   // Flag behaviour.
   flag_only_set_a: assert property (!flag && !wr_flags && !post_tick // [RL9]
      |=> !flag)
      else $error("Flag set without postscaler output.");

   flag_clear_a: assert property (wr_flags && !wdata_i[EBT_FLAG_BIT] && !post_tick // [RL16]
      |=> !flag)
      else $error("Flag clear lost.");

   // Control register and run bit.
   ctrl_write_a: assert property (wr_control // [RL12]
      |=> counter_control == $past(wdata_i[6:0]))
      else $error("Control write lost.");

   ctrl_hold_a: assert property (!wr_control // [RL12]
      |=> $stable(counter_control))
      else $error("Control changed without a write.");

   stop_no_match_a: assert property (!counter_run // [RL15]
      |-> !match && !post_tick)
      else $error("Match while stopped.");

   stop_scaler_a: assert property (!counter_run && !wr_counter && !wr_control // [RL15]
      |=> $stable(pre_cnt) && $stable(post_cnt))
      else $error("Scalers moved while stopped.");

   // Read path: data stand one cycle after the strobe and are zero otherwise.
   read_counter_a: assert property (rd_i && addr_i == EBT_OFS_COUNTER // [RL10]
      |=> rdata_o == $past(period_counter))
      else $error("Counter read wrong.");

   read_limit_a: assert property (rd_i && addr_i == EBT_OFS_LIMIT // [RL10]
      |=> rdata_o == $past(period_limit))
      else $error("Limit read wrong.");

   read_ctrl_a: assert property (rd_i && addr_i == EBT_OFS_CONTROL // [RL12]
      |=> rdata_o == {1'b0, $past(counter_control)})
      else $error("Control read wrong.");

   read_flag_a: assert property (rd_i && addr_i == EBT_OFS_FLAGS // [RL16]
      |=> rdata_o == {6'h00, $past(flag), 1'b0})
      else $error("Flag read wrong.");

   read_idle_a: assert property (!rd_i // [RL10]
      |=> rdata_o == 8'h00)
      else $error("Read data without a strobe.");

   wrap_c: cover property (pre_tick && at_limit);
   flag_c: cover property (post_tick && match_divide_select == 4'hF);
   div16_c: cover property (pre_tick && input_divide_select[1]);
   clear_c: cover property (wr_flags && post_tick);
   stop_c: cover property (wr_control && counter_run && !wdata_i[EBT_RUN_BIT]);
endmodule // ebt_timer

// *** verification/tb_top.sv ***
// Self-checking bench for the eight-bit period timer, driving its register port directly.
// Assumes the timer is the only design in the run and that match_o settles well before the falling edge.
`timescale 1ns/100ps
module tb_top;
   import ebt_pkg::*;
   logic                  mclk_i, resetn_i, wr_i, rd_i, match_o, period_match_flag_o;
   logic [EBT_ADDR_W-1:0] addr_i;
   logic [7:0]            wdata_i, rdata_o, v1, v2;
   int                    bad_count, n_checks, cyc, mc, last, gap, m0, i;
   int                    rat [4] = '{1, 4, 16, 16};
   ebt_timer u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .match_o(match_o), .period_match_flag_o(period_match_flag_o));
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic complete_run();
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask
   // Read data is only valid in the cycle after the strobe, so it is taken at that cycle's falling edge.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      @(negedge mclk_i);
      d = rdata_o;
   endtask
   // Match pulses are counted on the rising edge, and the spacing of the last two is kept.
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         complete_run();
      end
      if (match_o === 1'b1) begin
         mc   <= mc + 1;
         gap  <= cyc - last;
         last <= cyc;
      end
   end
   initial begin
      {resetn_i, wr_i, rd_i, addr_i, wdata_i, cyc, mc, last, gap} = '0;
      repeat (8) @(posedge mclk_i);
      resetn_i <= 1'b1;
      rd(EBT_OFS_COUNTER, v1); chk(v1, 16'h00);
      rd(EBT_OFS_LIMIT, v1);   chk(v1, 16'hFF);
      rd(EBT_OFS_CONTROL, v1); chk(v1, 16'h00);
      wr(EBT_OFS_LIMIT, 8'h5A);
      rd(EBT_OFS_LIMIT, v1);   chk(v1, 16'h5A);
      wr(EBT_OFS_COUNTER, 8'hA5);
      rd(EBT_OFS_COUNTER, v1); chk(v1, 16'hA5);
      wr(EBT_OFS_CONTROL, 8'hFB);
      rd(EBT_OFS_CONTROL, v1); chk(v1, 16'h7B);
      rd(EBT_OFS_COUNTER, v1); chk(v1, 16'hA5);
      wr(4'h2, 8'h33);
      rd(4'h2, v1);            chk(v1, 16'h00);
      // Each input divide code sets the match spacing at limit 3, four ticks of four clocks times the ratio.
      for (int k = 0; k < 4; k++) begin
         wr(EBT_OFS_LIMIT, 8'h03);
         wr(EBT_OFS_COUNTER, 8'h00);
         wr(EBT_OFS_CONTROL, {6'h01, k[1:0]});
         @(negedge mclk_i);
         m0 = mc;
         for (i = 0; i < 3000 && mc < m0 + 2; i++) @(negedge mclk_i);
         chk(16'(gap), 16'(16 * rat[k]));
      end
      // With limit zero every tick is a match, so the flag needs exactly code plus one matches.
      wr(EBT_OFS_LIMIT, 8'h00);
      for (int k = 0; k < 16; k++) begin
         wr(EBT_OFS_CONTROL, 8'h00);
         wr(EBT_OFS_FLAGS, 8'h00);
         @(negedge mclk_i);
         chk({15'h0, period_match_flag_o}, 16'h0);
         m0 = mc;
         wr(EBT_OFS_CONTROL, {1'b0, k[3:0], 3'b100});
         for (i = 0; i < 200 && period_match_flag_o !== 1'b1; i++) @(negedge mclk_i);
         chk(16'(mc - m0), 16'(k + 1));
      end
      repeat (100) @(posedge mclk_i);
      rd(EBT_OFS_FLAGS, v1);   chk({15'h0, v1[EBT_FLAG_BIT]}, 16'h1);
      // Stopping must freeze the counter and silence the match output.
      wr(EBT_OFS_LIMIT, 8'hFF);
      wr(EBT_OFS_COUNTER, 8'h10);
      repeat (40) @(posedge mclk_i);
      wr(EBT_OFS_CONTROL, 8'h00);
      rd(EBT_OFS_COUNTER, v1);
      m0 = mc;
      repeat (50) @(posedge mclk_i);
      wr(EBT_OFS_CONTROL, 8'h02);
      rd(EBT_OFS_COUNTER, v2); chk(v2, v1);
      chk(16'(mc - m0), 16'h0);
      chk(16'(v1 > 8'h10), 16'h1);
      complete_run();
   end
endmodule // tb_top
